// *** rtl/pulse_output_pkg.sv ***
// constants for the pulse output control block
package pulse_output_pkg;
   // register word indexes on the apb bus, placed at paddr bits 9:2
   localparam logic [7:0] DELAY_AUX_ADDR    = 8'ha1;
   localparam logic [7:0] PRIMARY_CTRL_ADDR = 8'ha4;
   // reset values
   localparam logic [7:0] DELAY_AUX_RESET    = 8'h00;
   localparam logic [7:0] PRIMARY_CTRL_RESET = 8'h00;
   // primary control field positions
   localparam int FIXED_DUTY_BIT = 7;
   localparam int HALF_FREQ_BIT  = 6;
   localparam int CYCLE_MSB      = 5;
   localparam int CYCLE_LSB      = 3;
   localparam int WIDTH_MSB      = 2;
   localparam int WIDTH_LSB      = 0;
   // delay register field positions
   localparam int DELAY_MSB         = 5;
   localparam int DELAY_LSB         = 3;
   localparam int CAPTURE_INV_BIT   = 2;
   localparam int CLOCK_DOUBLE_BIT  = 1;
   localparam int SRAM_DISABLE_BIT  = 0;
   localparam logic [7:0] DELAY_AUX_MASK = 8'h3f;
   // timing in clocks of one 67.8 ns step at 14.7456 MHz (one step = 1 clock)
   localparam int STEP_CLOCKS     = 1;
   localparam int CYCLE_BASE      = 15;
   localparam int CYCLE_STEP      = 10;
   localparam int WIDTH_ZERO      = 8;
   localparam int DELAY_BASE      = 4;
   localparam int FIXED_DUTY_DIV  = 12;
   localparam int FIXED_75_HIGH   = 9;
   localparam int FIXED_67_HIGH   = 8;
endpackage

// *** rtl/pulse_delay_line.sv ***
// delays a level by a programmable 4..11 clocks
`timescale 1ns/1ps
module pulse_delay_line
   import pulse_output_pkg::*;
#(
   parameter int DEPTH = 11
) (
   input  wire logic       core_clk_in,
   input  wire logic       reset_in,
   input  wire logic       level_in,
   input  wire logic [2:0] delay_code_in,
   output logic            level_out
);
   logic [DEPTH-1:0] tap_reg;
   logic [3:0]       sel;

   // shift register so every change is delayed, even changes closer than the delay
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         tap_reg <= '0;
      end else begin
         tap_reg <= {tap_reg[DEPTH-2:0], level_in};
      end
   end

   assign sel = 4'(DELAY_BASE - 1) + {1'b0, delay_code_in};

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         level_out <= 1'b0;
      end else begin
         level_out <= tap_reg[sel - 4'h1];
      end
   end
endmodule

// *** rtl/pulse_output_control.sv ***
// pulse output control with apb register access
`timescale 1ns/1ps
module pulse_output_control
   import pulse_output_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        reset_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             primary_pulse_output_out,
   output logic             delayed_pulse_output_out,
   output logic             fixed_duty_pulse_output_out,
   output logic             capture_pin_invert_out,
   output logic             clock_double_select_out,
   output logic             internal_sram_disable_out
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] primary_ctrl_reg;
   logic [7:0] delay_aux_reg;
   logic       access;
   logic       hit_primary;
   logic       hit_delay;
   logic       wr_ok;

   assign access      = psel_in && penable_in;
   assign hit_primary = paddr_in == {2'b00, PRIMARY_CTRL_ADDR, 2'b00};
   assign hit_delay   = paddr_in == {2'b00, DELAY_AUX_ADDR, 2'b00};
   // whole byte only: writes without the byte 0 strobe are refused with an error
   assign wr_ok       = pstrb_in[0];
   assign pready_out  = 1'b1;

   always_comb begin
      pslverr_out = 1'b0;
      if (access && !(hit_primary || hit_delay)) begin
         pslverr_out = 1'b1;
      end else if (access && pwrite_in && !wr_ok) begin
         pslverr_out = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         primary_ctrl_reg <= PRIMARY_CTRL_RESET;
      end else if (access && pwrite_in && hit_primary && wr_ok) begin
         primary_ctrl_reg <= pwdata_in[7:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         delay_aux_reg <= DELAY_AUX_RESET;
      end else if (access && pwrite_in && hit_delay && wr_ok) begin
         delay_aux_reg <= pwdata_in[7:0] & DELAY_AUX_MASK;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         prdata_out <= 32'h0;
      end else if (psel_in && !penable_in && !pwrite_in) begin
         if (hit_primary) begin
            prdata_out <= {24'h0, primary_ctrl_reg};
         end else if (hit_delay) begin
            prdata_out <= {24'h0, delay_aux_reg};
         end else begin
            prdata_out <= 32'h0;
         end
      end
   end

   assign capture_pin_invert_out    = delay_aux_reg[CAPTURE_INV_BIT];
   assign clock_double_select_out   = delay_aux_reg[CLOCK_DOUBLE_BIT];
   assign internal_sram_disable_out = delay_aux_reg[SRAM_DISABLE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // primary output: period and high time in steps
   logic [2:0] cycle_code;
   logic [2:0] width_code;
   logic [7:0] period_steps;
   logic [7:0] high_steps;
   logic [8:0] limit;
   logic [8:0] high_limit;
   logic [8:0] count_reg;

   assign cycle_code   = primary_ctrl_reg[CYCLE_MSB:CYCLE_LSB];
   assign width_code   = primary_ctrl_reg[WIDTH_MSB:WIDTH_LSB];
   assign period_steps = 8'(CYCLE_BASE) + 8'(CYCLE_STEP * cycle_code);
   assign high_steps   = (width_code == 3'h0) ? 8'(WIDTH_ZERO) : {5'h0, width_code};
   // half frequency doubles both period and high time so duty is kept
   assign limit      = primary_ctrl_reg[HALF_FREQ_BIT] ? {period_steps, 1'b0}
                                                       : {1'b0, period_steps};
   assign high_limit = primary_ctrl_reg[HALF_FREQ_BIT] ? {high_steps, 1'b0}
                                                       : {1'b0, high_steps};

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         count_reg <= 9'h0;
      end else if (count_reg >= limit - 9'h1) begin
         count_reg <= 9'h0;
      end else begin
         count_reg <= count_reg + 9'h1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         primary_pulse_output_out <= 1'b0;
      end else begin
         primary_pulse_output_out <= count_reg < high_limit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // delayed copy of the primary output
   pulse_delay_line #(
      .DEPTH (11)
   ) u_delay (
      .core_clk_in   (core_clk_in),
      .reset_in      (reset_in),
      .level_in      (primary_pulse_output_out),
      .delay_code_in (delay_aux_reg[DELAY_MSB:DELAY_LSB]),
      .level_out     (delayed_pulse_output_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // fixed duty output over a twelve-clock frame
   logic [3:0] duty_cnt_reg;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         duty_cnt_reg <= 4'h0;
      end else if (duty_cnt_reg == 4'(FIXED_DUTY_DIV - 1)) begin
         duty_cnt_reg <= 4'h0;
      end else begin
         duty_cnt_reg <= duty_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         fixed_duty_pulse_output_out <= 1'b0;
      end else if (primary_ctrl_reg[FIXED_DUTY_BIT]) begin
         fixed_duty_pulse_output_out <= duty_cnt_reg < 4'(FIXED_75_HIGH);
      end else begin
         fixed_duty_pulse_output_out <= duty_cnt_reg < 4'(FIXED_67_HIGH);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one check per delay code, since the depth of $past must be a constant
   // only the code used at the previous edge matters, so one stable cycle is enough
   for (genvar c = 0; c < 8; c++) begin : g_delay_chk
      a_delay_follows: assert property (@(posedge core_clk_in) disable iff (reset_in)
         $stable(delay_aux_reg[DELAY_MSB:DELAY_LSB])
         && delay_aux_reg[DELAY_MSB:DELAY_LSB] == 3'(c)
         |-> delayed_pulse_output_out == $past(primary_pulse_output_out, DELAY_BASE + c))
         else $error("delayed output off its tap");
   end

   // reserved bits never hold a one
   a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
      delay_aux_reg[7:6] == 2'b00)
      else $error("reserved bits set");

   // frame counter stays inside twelve clocks
   a_fixed_frame: assert property (@(posedge core_clk_in) disable iff (reset_in)
      duty_cnt_reg < 4'(FIXED_DUTY_DIV))
      else $error("duty counter overran");

   // a settling setting may leave one long cycle, so only check once stable
   a_count_bound: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $stable(primary_ctrl_reg) |-> count_reg < limit)
      else $error("period overrun");

   // a whole-byte write lands on the next edge
   a_write_lands: assert property (@(posedge core_clk_in) disable iff (reset_in)
      access && pwrite_in && hit_primary && pstrb_in[0]
      |=> primary_ctrl_reg == $past(pwdata_in[7:0]))
      else $error("primary write lost");

   // a refused write leaves both registers alone
   a_refused_keep: assert property (@(posedge core_clk_in) disable iff (reset_in)
      access && pwrite_in && (!pstrb_in[0] || !(hit_primary || hit_delay))
      |=> $stable(primary_ctrl_reg) && $stable(delay_aux_reg))
      else $error("refused write landed");

   // both duty settings keep the output high for at least eight clocks
   sequence s_fix_rise;
      $rose(fixed_duty_pulse_output_out);
   endsequence

   sequence s_fix_high;
      fixed_duty_pulse_output_out [*8];
   endsequence

   a_fixed_run: assert property (@(posedge core_clk_in) disable iff (reset_in)
      s_fix_rise |-> s_fix_high)
      else $error("fixed duty high run short");
endmodule

// *** bench/pulse_pin_monitor.sv ***
// external load on a pulse pin: measures high and low run lengths
`timescale 1ns/1ps
module pulse_pin_monitor (
   input  wire logic core_clk_in,
   input  wire logic reset_in,
   input  wire logic level_in,
   output int        high_len_out,
   output int        low_len_out,
   output int        edges_out
);
   int   run_len;
   logic last_level;
   ////////////////////////////////////////////////////////////////////////////
   // passive sink: it only samples, the pin is never loaded back
   always_ff @(posedge core_clk_in) begin
      last_level <= level_in;
      run_len <= (level_in !== last_level) ? 1 : run_len + 1;
      if (reset_in) begin
         edges_out <= 0;
      end else if (level_in !== last_level) begin
         edges_out <= edges_out + 1;
         if (last_level === 1'b1) begin
            high_len_out <= run_len;
         end else begin
            low_len_out <= run_len;
         end
      end
   end
endmodule

// *** bench/pulse_output_control_tb.sv ***
// self-checking bench for the pulse output control block
`timescale 1ns/1ps
module pulse_output_control_tb;
   import pulse_output_pkg::*;
   logic        core_clk_in = 0;
   logic        reset_in = 1;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0]  pstrb = '0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready, pslverr, err, prim, dly, fix, cap, dbl, sram;
   logic        dly_on = 0;
   logic [15:0] hist = '0;
   int          miscompares = 0;
   int          checked = 0;
   int          hp, lp, ep, hf, lf, ef, dcode, k, w, hi;
   logic [7:0]  v;
   logic [4:0]  r;
   localparam logic [11:0] DA = {2'b00, DELAY_AUX_ADDR, 2'b00};
   localparam logic [11:0] PA = {2'b00, PRIMARY_CTRL_ADDR, 2'b00};
   ////////////////////////////////////////////////////////////////////////////
   initial forever #20 core_clk_in = ~core_clk_in;
   pulse_output_control u_pulse_output_control (.core_clk_in(core_clk_in),
      .reset_in(reset_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .primary_pulse_output_out(prim),
      .delayed_pulse_output_out(dly), .fixed_duty_pulse_output_out(fix),
      .capture_pin_invert_out(cap), .clock_double_select_out(dbl),
      .internal_sram_disable_out(sram));
   pulse_pin_monitor u_mon_prim (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .level_in(prim), .high_len_out(hp), .low_len_out(lp), .edges_out(ep));
   pulse_pin_monitor u_mon_fix (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .level_in(fix), .high_len_out(hf), .low_len_out(lf), .edges_out(ef));
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic fail(string m);
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
      checked++;
      if (got !== exp) fail(m);
   endtask
   // one transfer; the first edge keeps back-to-back calls from double driving
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      int n;
      @(posedge core_clk_in);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk_in);
      penable <= 1;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fail("apb timeout");
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_edges(int cnt);
      int e0;
      int n;
      e0 = ep;
      for (n = 0; n < 2000 && ep < e0 + cnt; n++) @(posedge core_clk_in);
      if (ep < e0 + cnt) begin
         fail("no pulse edges");
         tally_and_finish();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // delayed output mirrors the primary output history
   always @(posedge core_clk_in) hist <= {hist[14:0], prim};
   always @(negedge core_clk_in) begin
      if (dly_on) begin
         checked++;
         if (dly !== hist[DELAY_BASE + dcode - 1]) fail("delayed output");
      end
   end
   initial begin
      void'($urandom(47356));
      repeat (12) @(posedge core_clk_in);
      reset_in <= 0;
      apb(0, DA, 0, 4'h0);
      chk(rd, 32'h0, "delay reset value");
      apb(0, PA, 0, 4'h0);
      chk(rd, 32'h0, "primary reset value");
      apb(1, DA, 32'hff, 4'h1);
      apb(0, DA, 0, 4'h0);
      chk(rd, 32'h3f, "reserved bits");
      chk({cap, dbl, sram}, 3'b111, "aux bits");
      apb(1, DA, 32'h07, 4'h0);
      chk(err, 1'b1, "partial write accepted");
      apb(1, PA, 32'hff, 4'h2);
      chk(err, 1'b1, "primary partial write accepted");
      apb(0, DA, 0, 4'h0);
      chk(rd, 32'h3f, "refused write landed");
      apb(0, PA, 0, 4'h0);
      chk(rd, 32'h0, "refused primary write landed");
      apb(1, 12'h288, 32'h01, 4'h1);
      chk(err, 1'b1, "unmapped accepted");
      // xor with one random draw still walks every width and mode code
      r = 5'($urandom);
      for (int i = 0; i < 8; i++) begin
         v = {i[1:0] ^ r[4:3], i[2:0], i[2:0] ^ r[2:0]};
         dly_on = 0;
         dcode = 7 - i;
         apb(1, DA, {26'h0, dcode[2:0], 3'b101}, 4'h1);
         apb(1, PA, {24'h0, v}, 4'h1);
         chk({cap, dbl, sram}, 3'b101, "aux bits");
         wait_edges(2);
         dly_on = 1;
         wait_edges(4);
         k = v[6] ? 2 : 1;
         w = (v[2:0] == 0) ? WIDTH_ZERO : v[2:0];
         chk(hp, w * k, "high time");
         chk(hp + lp, (CYCLE_BASE + CYCLE_STEP * i) * k, "period");
         hi = v[7] ? FIXED_75_HIGH : FIXED_67_HIGH;
         chk(hf, hi, "fixed duty high");
         chk(lf, FIXED_DUTY_DIV - hi, "fixed duty low");
      end
      tally_and_finish();
   end
endmodule
